// [core/sasq_pkg.sv]
// Constants, field positions and carrier types for the converter sequencer.
// Assumes a single 10 MHz clock and a plain register port with 16-bit data.
package sasq_pkg;

    // ************************************************************
    // Register map and field positions
    // ************************************************************
    localparam int          DATA_W      = 16;
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  ADDR_CTRL1  = 8'h00;
    localparam logic [7:0]  ADDR_CTRL2  = 8'h01;
    localparam logic [7:0]  ADDR_CTRL3  = 8'h02;
    localparam logic [7:0]  ADDR_SLOT0  = 8'h10;
    localparam logic [7:0]  ADDR_SLOTF  = 8'h1F;
    localparam int          NUM_SLOTS   = 16;

    // Control register 1 (adc_control_1).
    localparam int          B_ON        = 15;
    localparam int          B_SIDL      = 13;
    localparam int          B_DMABM     = 12;
    localparam int          B_RES       = 10;
    localparam int          B_OUTPUT_FORMAT      = 8;
    localparam int          B_SAMPLE_TRIGGER_SRC      = 5;
    localparam int          B_TRIGGER_GROUP_SEL     = 4;
    localparam int          B_SIM       = 3;
    localparam int          B_AUTO_SAMPLE_START      = 2;
    localparam int          B_SAMPLE_ACTIVE      = 1;
    localparam int          B_DONE      = 0;
    localparam logic [15:0] CTRL1_MASK  = 16'hB7FF;
    localparam logic [15:0] CTRL1_RST   = 16'h0000;

    // Control register 2: scan enable, count per event, DMA mode.
    localparam int          B_DMAEN     = 15;
    localparam int          B_SCAN      = 10;
    localparam int          B_CPE       = 2;
    localparam logic [15:0] CTRL2_MASK  = 16'h847C;
    localparam logic [15:0] CTRL2_RST   = 16'h0000;

    // Control register 3: internal sample counter length in cycles.
    localparam int          B_SAMC      = 8;
    localparam logic [15:0] CTRL3_MASK  = 16'h1F00;
    localparam logic [15:0] CTRL3_RST   = 16'h0000;

    // ************************************************************
    // Codes
    // ************************************************************
    localparam logic [2:0]  TRG_MANUAL  = 3'h0;
    localparam logic [2:0]  TRG_EXTPIN  = 3'h1;
    localparam logic [2:0]  TRG_TIMER3  = 3'h2;
    localparam logic [2:0]  TRG_PWMSEV  = 3'h3;
    localparam logic [2:0]  TRG_TIMER5  = 3'h4;
    localparam logic [2:0]  TRG_CTMU    = 3'h6;
    localparam logic [2:0]  TRG_COUNTER = 3'h7;
    localparam logic [1:0]  FMT_INT     = 2'h0;
    localparam logic [1:0]  FMT_SINT    = 2'h1;
    localparam logic [1:0]  FMT_FRAC    = 2'h2;
    localparam logic [1:0]  FMT_SFRAC   = 2'h3;

    typedef enum logic [1:0] {
        SASQ_IDLE    = 2'b00,
        SASQ_SAMPLE  = 2'b01,
        SASQ_CONVERT = 2'b10
    } sasq_state_t;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } sasq_bus_t;

    typedef struct packed {
        logic [2:0]  pwm_gen;
        logic        timer3;
        logic        timer5;
        logic        pwm_sevt;
        logic        ctmu;
        logic        ext_pin;
    } sasq_trig_t;

    typedef struct packed {
        logic        done;
        logic [5:0]  chan;
        logic [11:0] data;
    } sasq_conv_t;

endpackage : sasq_pkg

// [core/sasq_core.sv]
// Sequencer for a successive-approximation converter: sampling, trigger
// choice, completion flag, result formatting, 16-slot buffer and DMA mode.
// Assumes the analog converter answers conv_start_out with one conv_in.done
// pulse carrying the raw result, and that all inputs are clock-synchronous.
//
// The strobed register port and the placing of the registers are this design's own decisions.

// Notes on behaviour
// - Resolution bit: set 12-bit, clear 10-bit
// - No simultaneous sampling in 12-bit mode
// - Event flag after count of completed conversions
// - Scan list restarts when count reached
// - Non-DMA results fill 16 slots sequentially
// - Slot depends on order, not input
// - DMA mode: slot zero, address steps per count
// - Done cleared at convert start, set at end
// - Converter operates only with module on
// - Idle-stop bit halts converter in Idle
// - Build-order bit picks DMA address style
// - Four 10-bit output formats
// - Four 12-bit output formats
// - Group one: PWM generator triggers 1-3
// - Group zero trigger source codes
// - Sample bit set/cleared by software or hardware
// - Auto start resamples right after conversion
// - Done accepts only zero, without side effects
module sasq_core (
    // Clock and reset
    input  wire logic                 ref_clk_in,
    input  wire logic                 rst_in,
    // Register port
    input  wire sasq_pkg::sasq_bus_t  bus_in,
    output logic [15:0]               reg_rdata_out,
    // Device and trigger inputs
    input  wire logic                 idle_mode_in,
    input  wire sasq_pkg::sasq_trig_t trig_in,
    // Analog converter
    input  wire sasq_pkg::sasq_conv_t conv_in,
    output logic                      sample_out,
    output logic                      sim_sample_out,
    output logic                      conv_start_out,
    output logic [4:0]                scan_index_out,
    // Event and DMA
    output logic                      event_out,
    output logic                      dma_req_out,
    output logic [7:0]                dma_addr_out
);
    import sasq_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        sasq_state_t       st;
        logic [15:0]       ctrl1;
        logic [15:0]       ctrl2;
        logic [15:0]       ctrl3;
        logic [4:0]        smp_cnt;
        logic [4:0]        evt_cnt;
        logic [3:0]        wr_ptr;
        logic [4:0]        scan_idx;
        logic [7:0]        dma_blk;
        logic              ext_d;
        logic [15:0][15:0] slots;
        logic [15:0]       rdata;
        logic              conv_start;
        logic              sim_o;
        logic              evt;
        logic              dma_req;
        logic [7:0]        dma_addr;
    } sasq_regs_t;

    sasq_regs_t q_r;
    sasq_regs_t q_nxt;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [15:0] fmt_result(input logic       res12,
                                               input logic [1:0] output_format,
                                               input logic [11:0] d);
        logic [15:0] r;
        r = 16'h0000;
        if (res12) begin
            case (output_format)
                FMT_INT:  r = {4'h0, d};
                FMT_SINT: r = {{4{~d[11]}}, d};
                FMT_FRAC: r = {d, 4'h0};
                default:  r = {~d[11], d[10:0], 4'h0};
            endcase
        end else begin
            case (output_format)
                FMT_INT:  r = {6'h00, d[9:0]};
                FMT_SINT: r = {{6{~d[9]}}, d[9:0]};
                FMT_FRAC: r = {d[9:0], 6'h00};
                default:  r = {~d[9], d[8:0], 6'h00};
            endcase
        end
        return r;
    endfunction : fmt_result

    // Manual code is absent here: it ends sampling through a register write.
    function automatic logic trig_hit(input logic       group,
                                      input logic [2:0] code,
                                      input sasq_trig_t t,
                                      input logic       ext_edge,
                                      input logic       cnt_done);
        logic h;
        h = 1'b0;
        if (group) begin
            if (code < 3'h3) begin
                h = t.pwm_gen[code[1:0]];
            end
        end else begin
            case (code)
                TRG_EXTPIN:  h = ext_edge;
                TRG_TIMER3:  h = t.timer3;
                TRG_PWMSEV:  h = t.pwm_sevt;
                TRG_TIMER5:  h = t.timer5;
                TRG_CTMU:    h = t.ctmu;
                TRG_COUNTER: h = cnt_done;
                default:     h = 1'b0;
            endcase
        end
        return h;
    endfunction : trig_hit

    // ************************************************************
    // Next state
    // ************************************************************
    logic       on_w;
    logic       run_w;
    logic       manual_w;
    logic       start_conv;
    logic       complete_w;
    logic       last_w;
    logic [4:0] limit_w;
    logic [3:0] slot_w;

    always_comb begin
        q_nxt            = q_r;
        q_nxt.conv_start = 1'b0;
        q_nxt.evt        = 1'b0;
        q_nxt.dma_req    = 1'b0;
        q_nxt.rdata      = 16'h0000;
        q_nxt.ext_d      = trig_in.ext_pin;
        on_w     = q_r.ctrl1[B_ON];
        // Idle only freezes the sequencer so a wake resumes where it was.
        run_w    = on_w && !(q_r.ctrl1[B_SIDL] && idle_mode_in);
        manual_w = !q_r.ctrl1[B_TRIGGER_GROUP_SEL]
                   && q_r.ctrl1[B_SAMPLE_TRIGGER_SRC +: 3] == TRG_MANUAL;
        start_conv = 1'b0;
        complete_w = run_w && q_r.st == SASQ_CONVERT && conv_in.done;
        // Non-DMA mode ignores the top count bit: at most 16 slots.
        limit_w  = q_r.ctrl2[B_DMAEN] ? q_r.ctrl2[B_CPE +: 5]
                                      : {1'b0, q_r.ctrl2[B_CPE +: 4]};
        last_w   = q_r.evt_cnt == limit_w;
        slot_w   = q_r.ctrl2[B_DMAEN] ? 4'h0 : q_r.wr_ptr;

        // Register writes.
        if (bus_in.wr) begin
            case (bus_in.addr)
                ADDR_CTRL1: begin
                    q_nxt.ctrl1 = bus_in.wdata & CTRL1_MASK;
                    q_nxt.ctrl1[B_SAMPLE_ACTIVE] = q_r.ctrl1[B_SAMPLE_ACTIVE];
                    // Only a zero lands; a one leaves the flag as it was.
                    q_nxt.ctrl1[B_DONE] = q_r.ctrl1[B_DONE]
                                          && bus_in.wdata[B_DONE];
                    if (run_w && !q_r.ctrl1[B_AUTO_SAMPLE_START]
                        && q_r.st == SASQ_IDLE && bus_in.wdata[B_SAMPLE_ACTIVE]) begin
                        q_nxt.st            = SASQ_SAMPLE;
                        q_nxt.ctrl1[B_SAMPLE_ACTIVE] = 1'b1;
                        q_nxt.smp_cnt       = 5'h00;
                    end
                    if (run_w && manual_w && q_r.st == SASQ_SAMPLE
                        && !bus_in.wdata[B_SAMPLE_ACTIVE]) begin
                        start_conv = 1'b1;
                    end
                end
                ADDR_CTRL2: q_nxt.ctrl2 = bus_in.wdata & CTRL2_MASK;
                ADDR_CTRL3: q_nxt.ctrl3 = bus_in.wdata & CTRL3_MASK;
                default: ;
            endcase
        end

        // Register reads; unmapped addresses answer zero.
        if (bus_in.rd) begin
            if (bus_in.addr == ADDR_CTRL1) begin
                q_nxt.rdata = q_r.ctrl1;
                // The simultaneous bit reads zero in 12-bit mode.
                if (q_r.ctrl1[B_RES]) begin
                    q_nxt.rdata[B_SIM] = 1'b0;
                end
            end else if (bus_in.addr == ADDR_CTRL2) begin
                q_nxt.rdata = q_r.ctrl2;
            end else if (bus_in.addr == ADDR_CTRL3) begin
                q_nxt.rdata = q_r.ctrl3;
            end else if (bus_in.addr >= ADDR_SLOT0
                         && bus_in.addr <= ADDR_SLOTF) begin
                q_nxt.rdata = q_r.slots[bus_in.addr[3:0]];
            end
        end

        // Sequencer.
        if (!on_w) begin
            q_nxt.st            = SASQ_IDLE;
            q_nxt.ctrl1[B_SAMPLE_ACTIVE] = 1'b0;
            q_nxt.evt_cnt       = 5'h00;
            q_nxt.wr_ptr        = 4'h0;
            q_nxt.scan_idx      = 5'h00;
        end else if (run_w) begin
            case (q_r.st)
                SASQ_IDLE: begin
                    if (q_r.ctrl1[B_AUTO_SAMPLE_START]) begin
                        q_nxt.st            = SASQ_SAMPLE;
                        q_nxt.ctrl1[B_SAMPLE_ACTIVE] = 1'b1;
                        q_nxt.smp_cnt       = 5'h00;
                    end
                end
                SASQ_SAMPLE: begin
                    if (q_r.smp_cnt != 5'h1F) begin
                        q_nxt.smp_cnt = q_r.smp_cnt + 5'h01;
                    end
                    if (!manual_w && trig_hit(q_r.ctrl1[B_TRIGGER_GROUP_SEL],
                            q_r.ctrl1[B_SAMPLE_TRIGGER_SRC +: 3], trig_in,
                            trig_in.ext_pin && !q_r.ext_d,
                            q_r.smp_cnt >= q_r.ctrl3[B_SAMC +: 5])) begin
                        start_conv = 1'b1;
                    end
                end
                SASQ_CONVERT: begin
                    if (conv_in.done) begin
                        // Slot follows order only, never the input number.
                        q_nxt.slots[slot_w] = fmt_result(q_r.ctrl1[B_RES],
                            q_r.ctrl1[B_OUTPUT_FORMAT +: 2], conv_in.data);
                        q_nxt.ctrl1[B_DONE] = 1'b1;
                        q_nxt.dma_req = q_r.ctrl2[B_DMAEN];
                        q_nxt.dma_addr = q_r.ctrl1[B_DMABM] ? q_r.dma_blk
                            : {conv_in.chan[4:0], q_r.dma_blk[2:0]};
                        if (last_w) begin
                            q_nxt.evt     = 1'b1;
                            q_nxt.evt_cnt = 5'h00;
                            q_nxt.wr_ptr  = 4'h0;
                            if (q_r.ctrl2[B_SCAN]) begin
                                q_nxt.scan_idx = 5'h00;
                            end
                            if (q_r.ctrl2[B_DMAEN]) begin
                                q_nxt.dma_blk = q_r.dma_blk + 8'h01;
                            end
                        end else begin
                            q_nxt.evt_cnt = q_r.evt_cnt + 5'h01;
                            q_nxt.wr_ptr  = q_r.wr_ptr + 4'h1;
                            if (q_r.ctrl2[B_SCAN]) begin
                                q_nxt.scan_idx = q_r.scan_idx + 5'h01;
                            end
                        end
                        if (q_r.ctrl1[B_AUTO_SAMPLE_START]) begin
                            q_nxt.st            = SASQ_SAMPLE;
                            q_nxt.ctrl1[B_SAMPLE_ACTIVE] = 1'b1;
                            q_nxt.smp_cnt       = 5'h00;
                        end else begin
                            q_nxt.st = SASQ_IDLE;
                        end
                    end
                end
                default: q_nxt.st = SASQ_IDLE;
            endcase
            if (start_conv) begin
                q_nxt.st            = SASQ_CONVERT;
                q_nxt.ctrl1[B_SAMPLE_ACTIVE] = 1'b0;
                q_nxt.ctrl1[B_DONE] = 1'b0;
                q_nxt.conv_start    = 1'b1;
            end
        end
        q_nxt.sim_o = q_nxt.ctrl1[B_SIM] && !q_nxt.ctrl1[B_RES]
                      && q_nxt.st == SASQ_SAMPLE;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            q_r       <= '0;
            q_r.st    <= SASQ_IDLE;
            q_r.ctrl1 <= CTRL1_RST;
            q_r.ctrl2 <= CTRL2_RST;
            q_r.ctrl3 <= CTRL3_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign reg_rdata_out  = q_r.rdata;
    assign sample_out     = q_r.ctrl1[B_SAMPLE_ACTIVE];
    assign sim_sample_out = q_r.sim_o;
    assign conv_start_out = q_r.conv_start;
    assign scan_index_out = q_r.scan_idx;
    assign event_out      = q_r.evt;
    assign dma_req_out    = q_r.dma_req;
    assign dma_addr_out   = q_r.dma_addr;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence seq_complete;
        complete_w && !q_r.ctrl1[B_AUTO_SAMPLE_START];
    endsequence

    sequence seq_auto_complete;
        complete_w && q_r.ctrl1[B_AUTO_SAMPLE_START];
    endsequence

    sequence seq_manual_end;
        bus_in.wr && bus_in.addr == ADDR_CTRL1 && !bus_in.wdata[B_SAMPLE_ACTIVE]
        && run_w && manual_w && q_r.st == SASQ_SAMPLE;
    endsequence

    done_clear_a: assert property (
        conv_start_out |-> !q_r.ctrl1[B_DONE] && q_r.st == SASQ_CONVERT)
        else $error("done flag set while conversion starts");
    done_set_a: assert property (
        seq_complete |=> q_r.ctrl1[B_DONE] && q_r.st == SASQ_IDLE)
        else $error("done flag not set after completion");
    auto_start_a: assert property (
        seq_auto_complete |=> sample_out && q_r.st == SASQ_SAMPLE)
        else $error("auto start did not resume sampling");
    manual_conv_a: assert property (
        seq_manual_end |=> conv_start_out && !sample_out)
        else $error("manual clear did not start conversion");
    no_sim12_a: assert property (
        q_r.ctrl1[B_RES] |-> !sim_sample_out)
        else $error("simultaneous sampling in 12-bit mode");
    off_abort_a: assert property (
        !q_r.ctrl1[B_ON] |=> q_r.st == SASQ_IDLE && !sample_out)
        else $error("sequencer active while module off");
    event_wrap_a: assert property (
        event_out |-> q_r.evt_cnt == 5'h00 && q_r.wr_ptr == 4'h0
                      && (!q_r.ctrl2[B_SCAN] || scan_index_out == 5'h00))
        else $error("event without pointer restart");
    dma_pulse_a: assert property (
        dma_req_out |-> $past(complete_w) && $past(q_r.ctrl2[B_DMAEN])
                        ##1 !dma_req_out)
        else $error("dma request not a single completion pulse");
    idle_hold_a: assert property (
        q_r.ctrl1[B_ON] && q_r.ctrl1[B_SIDL] && idle_mode_in
        && !bus_in.wr |=> $stable(q_r.st) && !conv_start_out)
        else $error("converter moved during idle stop");

endmodule : sasq_core

// [tb/sasq_adc_model.sv]
// Behavioural model of the analog converter behind the sequencer.
// Assumes one conv_start_out pulse per conversion and a shared clock.
module sasq_adc_model
    import sasq_pkg::*;
#(
    parameter int LAT = 3
) (
    // Clock and reset
    input  wire logic                 ref_clk_in,
    input  wire logic                 rst_in,
    // Request from the sequencer
    input  wire logic                 start_in,
    input  wire logic [11:0]          raw_in,
    input  wire logic [5:0]           chan_in,
    // Answer
    output sasq_pkg::sasq_conv_t      conv_out
);
    int cnt_r;

    // Outside the done pulse the lines show the inverse of the last result,
    // so a sequencer that samples them late reads garbage, not a match.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r    <= 0;
            conv_out <= '0;
        end else begin
            conv_out.done <= 1'b0;
            if (start_in) begin
                cnt_r <= LAT;
            end else if (cnt_r > 0) begin
                cnt_r <= cnt_r - 1;
            end
            if (cnt_r == 1) begin
                conv_out <= '{1'b1, chan_in, raw_in};
            end else if (conv_out.done) begin
                conv_out.chan <= ~conv_out.chan;
                conv_out.data <= ~conv_out.data;
            end
        end
    end
endmodule : sasq_adc_model

// [tb/tb_sasq_core.sv]
// Self-checking bench for the converter sequencer.
// Assumes the converter model answers each start after three cycles.
module tb_sasq_core;
    timeunit 1ns;
    timeprecision 1ns;
    import sasq_pkg::*;

    typedef struct packed {
        logic [15:0] cfg;
        logic [7:0]  trig;
        logic        idle;
        logic [11:0] raw;
        logic        go;
        logic [15:0] dout;
    } sasq_row_t;

    // ****************************************************************
    // Row table: control word, trigger lines, idle, raw, start, result
    // ****************************************************************
    localparam sasq_row_t ROWS [17] = '{
        '{16'h0008, 8'h00, 1'b0, 12'hD5A, 1'b1, 16'h015A},
        '{16'h0108, 8'h00, 1'b0, 12'hD5A, 1'b1, 16'hFD5A},
        '{16'h0208, 8'h00, 1'b0, 12'hD5A, 1'b1, 16'h5680},
        '{16'h0308, 8'h00, 1'b0, 12'hD5A, 1'b1, 16'hD680},
        '{16'h0408, 8'h00, 1'b0, 12'h5A3, 1'b1, 16'h05A3},
        '{16'h0508, 8'h00, 1'b0, 12'h5A3, 1'b1, 16'hF5A3},
        '{16'h0608, 8'h00, 1'b0, 12'h5A3, 1'b1, 16'h5A30},
        '{16'h0708, 8'h00, 1'b0, 12'h5A3, 1'b1, 16'hDA30},
        '{16'h0020, 8'h01, 1'b0, 12'h123, 1'b1, 16'h0123},
        '{16'h0040, 8'h10, 1'b0, 12'h124, 1'b1, 16'h0124},
        '{16'h0060, 8'h04, 1'b0, 12'h125, 1'b1, 16'h0125},
        '{16'h0080, 8'h08, 1'b0, 12'h126, 1'b1, 16'h0126},
        '{16'h00C0, 8'h02, 1'b0, 12'h127, 1'b1, 16'h0127},
        '{16'h00E0, 8'h00, 1'b0, 12'h128, 1'b1, 16'h0128},
        '{16'h0010, 8'h20, 1'b0, 12'h129, 1'b1, 16'h0129},
        '{16'h0030, 8'h40, 1'b0, 12'h12A, 1'b1, 16'h012A},
        '{16'h0050, 8'h80, 1'b0, 12'h12B, 1'b1, 16'h012B}
    };

    logic        ref_clk_in, rst_in, idle_mode_in;
    sasq_bus_t   bus_in;
    sasq_trig_t  trig_in;
    sasq_conv_t  conv_in;
    logic [15:0] reg_rdata_out, d;
    logic        sample_out, sim_sample_out, conv_start_out;
    logic        event_out, dma_req_out;
    logic [4:0]  scan_index_out;
    logic [7:0]  dma_addr_out, last_addr;
    logic [11:0] raw;
    logic [5:0]  chan;
    int          n_mismatch, n_tests, n_start, n_ev, n_dma, cyc, s0;
    sasq_row_t   r;

    sasq_core i_sasq_core (.ref_clk_in, .rst_in, .bus_in, .reg_rdata_out,
        .idle_mode_in, .trig_in, .conv_in, .sample_out, .sim_sample_out,
        .conv_start_out, .scan_index_out, .event_out, .dma_req_out,
        .dma_addr_out);
    sasq_adc_model #(.LAT(3)) i_sasq_adc_model (.ref_clk_in, .rst_in,
        .start_in(conv_start_out), .raw_in(raw), .chan_in(chan),
        .conv_out(conv_in));

    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    // Pulses last one cycle, so they are counted here rather than polled.
    always @(posedge ref_clk_in) begin
        cyc++;
        if (conv_start_out === 1'b1) n_start++;
        if (event_out === 1'b1) n_ev++;
        if (dma_req_out === 1'b1) begin
            n_dma++;
            last_addr = dma_addr_out;
        end
        if (cyc == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge ref_clk_in);
        bus_in <= '{1'b1, 1'b0, a, v};
        @(posedge ref_clk_in);
        bus_in.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge ref_clk_in);
        bus_in <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge ref_clk_in);
        bus_in.rd <= 1'b0;
        #1 v = reg_rdata_out;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        chk(v, exp);
    endtask : rchk

    // Clearing done just before sampling keeps a stale flag out of polls.
    task automatic conv(input logic [15:0] c);
        wr(ADDR_CTRL1, c);
        wr(ADDR_CTRL1, c | 16'h0002);
        wr(ADDR_CTRL1, c);
        repeat (20) @(posedge ref_clk_in);
    endtask : conv

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rst_in = 1'b1;
        bus_in = '0;
        trig_in = '0;
        idle_mode_in = 1'b0;
        raw = 12'h000;
        chan = 6'h00;
        repeat (8) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rchk(ADDR_CTRL1, 16'h0000);
        rchk(ADDR_CTRL2, 16'h0000);
        rchk(ADDR_CTRL3, 16'h0000);
        rchk(8'h05, 16'h0000);
        wr(ADDR_CTRL1, 16'h0002);
        #1 chk({15'h0, sample_out}, 16'h0000);
        wr(ADDR_CTRL3, 16'h0300);
        foreach (ROWS[i]) begin
            r = ROWS[i];
            raw = r.raw;
            wr(ADDR_CTRL1, 16'h0000);
            wr(ADDR_CTRL1, 16'h8000 | r.cfg);
            wr(ADDR_CTRL1, 16'h8002 | r.cfg);
            #1 chk({15'h0, sample_out}, 16'h0001);
            chk({15'h0, sim_sample_out}, {15'h0, r.cfg[3] & ~r.cfg[10]});
            s0 = n_start;
            @(posedge ref_clk_in);
            trig_in <= r.trig;
            if (r.cfg[7:4] == 4'h0) wr(ADDR_CTRL1, 16'h8000 | r.cfg);
            repeat (20) @(posedge ref_clk_in);
            trig_in <= '0;
            chk({15'h0, n_start != s0}, {15'h0, r.go});
            rchk(ADDR_SLOT0, r.dout);
            rd(ADDR_CTRL1, d);
            chk({15'h0, d[0]}, 16'h0001);
        end
        // Wrong source, reserved codes and a stop in Idle must not start.
        foreach (ROWS[i]) if (i < 4) begin
            wr(ADDR_CTRL1, 16'h0000);
            d = (i == 3) ? 16'hA040 : (i == 1) ? 16'h80A0
                : (i == 2) ? 16'h8070 : 16'h8040;
            // The sample bit only acts once the module is already on.
            wr(ADDR_CTRL1, d);
            wr(ADDR_CTRL1, d | 16'h0002);
            s0 = n_start;
            @(posedge ref_clk_in);
            idle_mode_in <= (i == 3);
            trig_in <= (i == 0) ? 8'h08 : (i == 3 ? 8'h10 : 8'hFF);
            repeat (20) @(posedge ref_clk_in);
            trig_in <= '0;
            idle_mode_in <= 1'b0;
            chk(16'(n_start - s0), 16'h0000);
        end
        wr(ADDR_CTRL1, 16'h0000);
        wr(ADDR_CTRL2, 16'h0408);
        for (int i = 0; i < 4; i++) begin
            raw = 12'h100 + 12'(i);
            chan = 6'(7 - i);
            s0 = n_ev;
            conv(16'h8000);
            chk({15'h0, n_ev != s0}, {15'h0, i == 2});
            chk({11'h0, scan_index_out}, 16'((i + 1) % 3));
        end
        rchk(ADDR_SLOT0, 16'h0103);
        rchk(ADDR_SLOT0 + 8'h01, 16'h0101);
        rchk(ADDR_SLOT0 + 8'h02, 16'h0102);
        wr(ADDR_CTRL1, 16'h0000);
        wr(ADDR_CTRL2, 16'h8004);
        for (int i = 0; i < 3; i++) begin
            raw = 12'h200 + 12'(i);
            s0 = n_dma;
            conv(16'h9000);
            chk(16'(n_dma - s0), 16'h0001);
            rchk(ADDR_SLOT0, 16'h0200 + 16'(i));
            if (i != 1) chk({8'h00, last_addr}, 16'(i / 2));
        end
        rchk(ADDR_SLOT0 + 8'h01, 16'h0101);
        wr(ADDR_CTRL1, 16'h0000);
        chan = 6'h05;
        conv(16'h8000);
        // The block counter survives switch-off, so it still holds one here.
        chk({8'h00, last_addr}, 16'h0029);
        rchk(ADDR_CTRL1, 16'h8001);
        wr(ADDR_CTRL1, 16'h8000);
        rchk(ADDR_CTRL1, 16'h8000);
        wr(ADDR_CTRL1, 16'h8001);
        rchk(ADDR_CTRL1, 16'h8000);
        // Under auto start, control 1 is not rewritten until switch-off.
        wr(ADDR_CTRL1, 16'h0000);
        wr(ADDR_CTRL2, 16'h0000);
        wr(ADDR_CTRL1, 16'h8044);
        repeat (3) @(posedge ref_clk_in);
        chk({15'h0, sample_out}, 16'h0001);
        trig_in <= 8'h10;
        @(posedge ref_clk_in);
        trig_in <= '0;
        repeat (20) @(posedge ref_clk_in);
        rchk(ADDR_CTRL1, 16'h8047);
        wr(ADDR_CTRL1, 16'h0000);
        // Switch-off lands at the write edge; the abort follows one edge on.
        @(posedge ref_clk_in);
        #1 chk({15'h0, sample_out}, 16'h0000);
        give_verdict();
    end
endmodule : tb_sasq_core
